//--- led_fault_ctrl.sv
// Summary of operation
// - Non-string faults enter backoff, stop converter and sinks, pull fault low.
// - Backoff waits 100 ms, returns active if clear, releasing fault.
// - Open or short string stays active, disables that sink, asserts fault.
// - Enable low 2 to 20 us clears string faults; LEDs off, fault released.
// - Enable low beyond the clear window goes to standby; high restarts.
// - Supply overvoltage from soft start, declared after 100 us.
// - Output overvoltage from active entry, declared after 560 ms.
// - After output overvoltage use 50 ms; restore 560 ms after 160 ms active.
// - Supply undervoltage sensed always, declared after 100 us.
// - String below low level at maximum target flags open, removes string.
// - String above short level with another in window flags short.
// - Shorted string leaves voltage loop and its sink turns off.
// - Thermal monitored from soft start; recovery at backoff expiry once comparator deasserts.
// - Regulator above threshold enters standby, which only watches enable, undervoltage and the regulator.
// - Enable high in standby starts converter and sink power-up.
// - Grounded outputs found at start stay disabled and excluded.
// - Each per-string headroom and short comparator is filtered for 1 us; ground comparators are not.
`timescale 1ns/10ps
module led_fault_ctrl #(
  parameter logic [31:0] BACKOFF_CYC = led_fault_pkg::BACKOFF_CYC,
  parameter logic [31:0] OV_SLOW_CYC = led_fault_pkg::OV_SLOW_CYC,
  parameter logic [31:0] OV_FAST_CYC = led_fault_pkg::OV_FAST_CYC,
  parameter logic [31:0] OV_REARM_CYC = led_fault_pkg::OV_REARM_CYC,
  parameter logic [31:0] SUPPLY_FILT_CYC = led_fault_pkg::SUPPLY_FILT_CYC,
  parameter logic [31:0] UV_FILT_CYC = led_fault_pkg::UV_FILT_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic regulatorOk,
  input wire logic ioSupplyEnable,
  input wire logic supplyOvComp,
  input wire logic outputOvComp,
  input wire logic supplyUvComp,
  input wire logic thermalComp,
  input wire logic adaptAtMax,
  input wire logic [2:0] headroomLow,
  input wire logic [2:0] headroomMid,
  input wire logic [2:0] shortHigh,
  input wire logic [2:0] groundComp,
  output logic boostEnable,
  output logic [2:0] sinkEnable,
  output logic [2:0] loopInclude,
  output logic faultPinOut,
  output logic faultPinOeB,
  output logic supplyOvervoltageFault,
  output logic outputOvervoltageFault,
  output logic supplyUndervoltageFault,
  output logic thermalShutdownFault,
  output logic [2:0] openStringFault,
  output logic [2:0] shortedStringFault,
  output logic [2:0] stateCode
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rstPipe;
  logic rstN;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end

  assign rstN = rstPipe[1];

  // ----------------------------------------------------------------
  // Input synchronisers and filters
  // ----------------------------------------------------------------
  logic [led_fault_pkg::SYNC_W-1:0] syncIn;
  logic [led_fault_pkg::SYNC_W-1:0] syncV;
  logic [led_fault_pkg::STR_FILT_N-1:0] strFilt;
  logic [2:0] lowF;
  logic [2:0] midF;
  logic [2:0] highF;
  logic atMaxF;
  logic supOvF;
  logic outOvF;
  logic uvF;
  logic [31:0] ovLimit;

  typedef struct packed {
    led_fault_pkg::state_t state;
    logic [31:0] timer;
    logic [11:0] enLowCnt;
    logic ovFast;
    logic [2:0] grounded;
    logic [2:0] openFlag;
    logic [2:0] shortFlag;
    logic boostEn;
    logic [2:0] sinkEn;
    logic [2:0] loopInc;
    logic faultOeB;
  } ctrl_t;

  ctrl_t s_r;
  ctrl_t s_nxt;

  assign syncIn = {groundComp, regulatorOk, ioSupplyEnable, thermalComp, supplyUvComp,
                   outputOvComp, supplyOvComp, adaptAtMax, shortHigh, headroomMid, headroomLow};

  level_sync #(.W(led_fault_pkg::SYNC_W)) uSync (
    .clk_sys(clk_sys),
    .rstN(rstN),
    .asyncIn(syncIn),
    .syncOut(syncV)
  );

  for (genvar g = 0; g < led_fault_pkg::STR_FILT_N; g++) begin : gStrFilt
    persist_filter uFilt (
      .clk_sys(clk_sys),
      .rstN(rstN),
      .clear(1'b0),
      .sampleIn(syncV[g]),
      .limit(led_fault_pkg::STRING_FILT_CYC),
      .filtOut(strFilt[g])
    );
  end

  assign lowF = strFilt[led_fault_pkg::SYNC_LOW_LSB +: 3];
  assign midF = strFilt[led_fault_pkg::SYNC_MID_LSB +: 3];
  assign highF = strFilt[led_fault_pkg::SYNC_HIGH_LSB +: 3];
  assign atMaxF = strFilt[led_fault_pkg::SYNC_ATMAX];

  persist_filter uSupOv (
    .clk_sys(clk_sys),
    .rstN(rstN),
    .clear(s_r.state == led_fault_pkg::ST_STANDBY || s_r.state == led_fault_pkg::ST_POWER_OFF),
    .sampleIn(syncV[led_fault_pkg::SYNC_SUPOV]),
    .limit(SUPPLY_FILT_CYC),
    .filtOut(supOvF)
  );

  assign ovLimit = s_r.ovFast ? OV_FAST_CYC : OV_SLOW_CYC;

  persist_filter uOutOv (
    .clk_sys(clk_sys),
    .rstN(rstN),
    .clear(s_r.state != led_fault_pkg::ST_ACTIVE),
    .sampleIn(syncV[led_fault_pkg::SYNC_OUTOV]),
    .limit(ovLimit),
    .filtOut(outOvF)
  );

  persist_filter uUv (
    .clk_sys(clk_sys),
    .rstN(rstN),
    .clear(1'b0),
    .sampleIn(syncV[led_fault_pkg::SYNC_UV]),
    .limit(UV_FILT_CYC),
    .filtOut(uvF)
  );

  // ----------------------------------------------------------------
  // State control
  // ----------------------------------------------------------------
  function automatic logic inWindow(input logic low, input logic mid);
    inWindow = !low && !mid;
  endfunction

  logic ioEnS;
  logic porOkS;
  logic thermS;
  logic enLong;
  logic clearPulse;
  logic blank;
  logic faultCond;
  logic rawCond;
  logic [2:0] live;
  logic [2:0] openSet;
  logic [2:0] shortSet;
  logic [2:0] other;
  logic [2:0] strOff;

  assign ioEnS = syncV[led_fault_pkg::SYNC_EN];
  assign porOkS = syncV[led_fault_pkg::SYNC_POR];
  assign thermS = syncV[led_fault_pkg::SYNC_THERM];

  always_comb begin
    s_nxt = s_r;
    enLong = s_r.enLowCnt > led_fault_pkg::EN_CLEAR_MAX_CYC;
    clearPulse = ioEnS && s_r.enLowCnt >= led_fault_pkg::EN_CLEAR_MIN_CYC && !enLong;
    blank = s_r.state == led_fault_pkg::ST_ACTIVE && !ioEnS;
    faultCond = supOvF || outOvF || uvF || thermS;
    rawCond = syncV[led_fault_pkg::SYNC_SUPOV] || syncV[led_fault_pkg::SYNC_OUTOV]
              || syncV[led_fault_pkg::SYNC_UV] || thermS;
    live = ~(s_r.grounded | s_r.openFlag | s_r.shortFlag);
    other = 3'h0;
    for (int i = 0; i < 3; i++) begin
      for (int j = 0; j < 3; j++) begin
        if (j != i && live[j] && inWindow(lowF[j], midF[j])) begin
          other[i] = 1'b1;
        end
      end
    end
    openSet = live & lowF & {3{atMaxF && !blank}};
    shortSet = live & highF & other & {3{!blank}};
    if (ioEnS) begin
      s_nxt.enLowCnt = 12'h000;
    end else if (!enLong) begin
      s_nxt.enLowCnt = s_r.enLowCnt + 12'h001;
    end
    unique case (s_r.state)
      led_fault_pkg::ST_POWER_OFF: begin
        s_nxt.state = led_fault_pkg::ST_STANDBY;
      end
      led_fault_pkg::ST_STANDBY: begin
        s_nxt.timer = 32'h0;
        s_nxt.grounded = 3'h0;
        s_nxt.openFlag = 3'h0;
        s_nxt.shortFlag = 3'h0;
        s_nxt.ovFast = 1'b0;
        if (ioEnS && !uvF) begin
          s_nxt.state = led_fault_pkg::ST_STARTUP;
        end
      end
      led_fault_pkg::ST_STARTUP: begin
        s_nxt.timer = s_r.timer + 32'h1;
        if (enLong) begin
          s_nxt.state = led_fault_pkg::ST_STANDBY;
        end else if (faultCond) begin
          s_nxt.state = led_fault_pkg::ST_BACKOFF;
          s_nxt.timer = 32'h0;
        end else if (s_r.timer >= led_fault_pkg::GROUND_SENSE_CYC - 32'h1) begin
          s_nxt.grounded = syncV[led_fault_pkg::SYNC_GND_LSB +: 3];
          s_nxt.state = led_fault_pkg::ST_ACTIVE;
          s_nxt.timer = 32'h0;
        end
      end
      led_fault_pkg::ST_ACTIVE: begin
        if (s_r.timer < OV_REARM_CYC) begin
          s_nxt.timer = s_r.timer + 32'h1;
        end else begin
          s_nxt.ovFast = 1'b0;
        end
        s_nxt.openFlag = (s_r.openFlag & ~{3{clearPulse}}) | openSet;
        s_nxt.shortFlag = (s_r.shortFlag & ~{3{clearPulse}}) | shortSet;
        if (enLong) begin
          s_nxt.state = led_fault_pkg::ST_STANDBY;
        end else if (faultCond) begin
          s_nxt.state = led_fault_pkg::ST_BACKOFF;
          s_nxt.timer = 32'h0;
          s_nxt.ovFast = s_r.ovFast || outOvF;
        end
      end
      led_fault_pkg::ST_BACKOFF: begin
        s_nxt.timer = s_r.timer + 32'h1;
        if (enLong) begin
          s_nxt.state = led_fault_pkg::ST_STANDBY;
        end else if (s_r.timer >= BACKOFF_CYC - 32'h1) begin
          s_nxt.timer = 32'h0;
          if (!rawCond) begin
            s_nxt.state = led_fault_pkg::ST_ACTIVE;
          end
        end
      end
      default: begin
        s_nxt.state = led_fault_pkg::ST_POWER_OFF;
      end
    endcase
    if (!porOkS) begin
      s_nxt.state = led_fault_pkg::ST_POWER_OFF;
    end
    strOff = s_nxt.grounded | s_nxt.openFlag | s_nxt.shortFlag;
    s_nxt.boostEn = s_nxt.state == led_fault_pkg::ST_STARTUP
                    || s_nxt.state == led_fault_pkg::ST_ACTIVE;
    s_nxt.sinkEn = (s_nxt.state == led_fault_pkg::ST_ACTIVE && ioEnS) ? ~strOff : 3'h0;
    s_nxt.loopInc = ~strOff;
    s_nxt.faultOeB = !(s_nxt.state == led_fault_pkg::ST_BACKOFF
                       || ((|(s_nxt.openFlag | s_nxt.shortFlag)) && ioEnS));
  end

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      s_r <= '{state: led_fault_pkg::STATE_RST, faultOeB: 1'b1, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign boostEnable = s_r.boostEn;
  assign sinkEnable = s_r.sinkEn;
  assign loopInclude = s_r.loopInc;
  assign faultPinOut = 1'b0;
  assign faultPinOeB = s_r.faultOeB;
  assign supplyOvervoltageFault = supOvF;
  assign outputOvervoltageFault = outOvF;
  assign supplyUndervoltageFault = uvF;
  assign thermalShutdownFault = thermS;
  assign openStringFault = s_r.openFlag;
  assign shortedStringFault = s_r.shortFlag;
  assign stateCode = s_r.state;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstN);

  backoff_outputs_a: assert property (
    s_r.state == led_fault_pkg::ST_BACKOFF |-> !s_r.boostEn && s_r.sinkEn == 3'h0
      && !s_r.faultOeB)
    else $error("Backoff state does not stop outputs.");

  backoff_wait_a: assert property (
    (s_r.state == led_fault_pkg::ST_ACTIVE && $past(s_r.state) == led_fault_pkg::ST_BACKOFF)
      |-> $past(s_r.timer) == BACKOFF_CYC - 32'h1)
    else $error("Backoff left before its wait elapsed.");

  string_stay_a: assert property (
    $rose(|s_r.openFlag) |-> s_r.state == led_fault_pkg::ST_ACTIVE
      && (s_r.openFlag & s_r.sinkEn) == 3'h0)
    else $error("Open string left active state or kept its sink.");

  clear_blank_a: assert property (
    (s_r.state == led_fault_pkg::ST_ACTIVE && !$past(ioEnS)) |-> s_r.sinkEn == 3'h0
      && s_r.faultOeB)
    else $error("Clearing pulse did not blank LEDs and release fault.");

  long_low_a: assert property (
    (s_r.state != led_fault_pkg::ST_POWER_OFF && s_r.enLowCnt > led_fault_pkg::EN_CLEAR_MAX_CYC
      && porOkS && !ioEnS) |=> s_r.state == led_fault_pkg::ST_STANDBY)
    else $error("Long enable low did not reach standby.");

  supply_ov_a: assert property (
    (s_r.state inside {led_fault_pkg::ST_STARTUP, led_fault_pkg::ST_ACTIVE} && supOvF
      && porOkS && s_r.enLowCnt <= led_fault_pkg::EN_CLEAR_MAX_CYC)
      |=> s_r.state == led_fault_pkg::ST_BACKOFF)
    else $error("Supply overvoltage did not enter backoff.");

  fast_filter_a: assert property (
    $rose(s_r.ovFast) |-> $past(s_r.state) == led_fault_pkg::ST_ACTIVE
      && s_r.state == led_fault_pkg::ST_BACKOFF && ovLimit == OV_FAST_CYC)
    else $error("Short filter chosen without an output overvoltage fault.");

  grounded_off_a: assert property (
    (s_r.grounded & (s_r.sinkEn | s_r.loopInc)) == 3'h0)
    else $error("Grounded output is enabled or in the loop.");

  standby_idle_a: assert property (
    s_r.state == led_fault_pkg::ST_STANDBY |-> !s_r.boostEn && s_r.sinkEn == 3'h0)
    else $error("Standby drives converter or sinks.");

  standby_start_a: assert property (
    (s_r.state == led_fault_pkg::ST_STANDBY && ioEnS && !uvF && porOkS)
      |=> s_r.state == led_fault_pkg::ST_STARTUP)
    else $error("Enable in standby did not start power-up.");

endmodule

//--- led_fault_pkg.sv
package led_fault_pkg;

  // ----------------------------------------------------------------
  // Clock rate
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned CLK_KHZ = 125000;
  localparam int unsigned NUM_STRINGS = 3;

  // ----------------------------------------------------------------
  // Times in their own units
  // ----------------------------------------------------------------
  localparam int unsigned BACKOFF_MS = 100;
  localparam int unsigned OV_SLOW_MS = 560;
  localparam int unsigned OV_FAST_MS = 50;
  localparam int unsigned OV_REARM_MS = 160;
  localparam int unsigned SUPPLY_FILT_US = 100;
  localparam int unsigned UV_FILT_US = 100;
  localparam int unsigned STRING_FILT_US = 1;
  localparam int unsigned EN_CLEAR_MIN_US = 2;
  localparam int unsigned EN_CLEAR_MAX_US = 20;
  localparam int unsigned GROUND_SENSE_US = 10;

  // ----------------------------------------------------------------
  // Times in clock cycles
  // ----------------------------------------------------------------
  localparam logic [31:0] BACKOFF_CYC = 32'(BACKOFF_MS * CLK_KHZ);
  localparam logic [31:0] OV_SLOW_CYC = 32'(OV_SLOW_MS * CLK_KHZ);
  localparam logic [31:0] OV_FAST_CYC = 32'(OV_FAST_MS * CLK_KHZ);
  localparam logic [31:0] OV_REARM_CYC = 32'(OV_REARM_MS * CLK_KHZ);
  localparam logic [31:0] SUPPLY_FILT_CYC = 32'(SUPPLY_FILT_US * CLK_MHZ);
  localparam logic [31:0] UV_FILT_CYC = 32'(UV_FILT_US * CLK_MHZ);
  localparam logic [31:0] STRING_FILT_CYC = 32'(STRING_FILT_US * CLK_MHZ);
  localparam logic [31:0] GROUND_SENSE_CYC = 32'(GROUND_SENSE_US * CLK_MHZ);
  localparam logic [11:0] EN_CLEAR_MIN_CYC = 12'(EN_CLEAR_MIN_US * CLK_MHZ);
  localparam logic [11:0] EN_CLEAR_MAX_CYC = 12'(EN_CLEAR_MAX_US * CLK_MHZ);

  // ----------------------------------------------------------------
  // Positions in the synchronised input vector
  // ----------------------------------------------------------------
  localparam int unsigned SYNC_LOW_LSB = 0;
  localparam int unsigned SYNC_MID_LSB = 3;
  localparam int unsigned SYNC_HIGH_LSB = 6;
  localparam int unsigned SYNC_ATMAX = 9;
  localparam int unsigned SYNC_SUPOV = 10;
  localparam int unsigned SYNC_OUTOV = 11;
  localparam int unsigned SYNC_UV = 12;
  localparam int unsigned SYNC_THERM = 13;
  localparam int unsigned SYNC_EN = 14;
  localparam int unsigned SYNC_POR = 15;
  localparam int unsigned SYNC_GND_LSB = 16;
  localparam int unsigned SYNC_W = 19;
  localparam int unsigned STR_FILT_N = 10;

  // ----------------------------------------------------------------
  // Operating states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_POWER_OFF = 3'h0,
    ST_STANDBY = 3'h1,
    ST_STARTUP = 3'h2,
    ST_ACTIVE = 3'h3,
    ST_BACKOFF = 3'h4
  } state_t;

  localparam state_t STATE_RST = ST_POWER_OFF;

endpackage

//--- led_host_model.sv
`timescale 1ns/10ps
module led_host_model (
  input wire logic clk_sys,
  input wire logic faultPinOut,
  input wire logic faultPinOeB,
  output logic ioSupplyEnable,
  output logic faultLine
);
  // --------
  // Fault line
  // --------
  // The open-drain line has a pull-up, so it reads high when released.
  assign faultLine = faultPinOeB ? 1'h1 : faultPinOut;

  // --------
  // Enable pin
  // --------
  initial ioSupplyEnable = 1'h0;

  task automatic setEnable(input logic v);
    @(negedge clk_sys);
    ioSupplyEnable = v;
  endtask

  // Holds the enable low for a count of cycles, then raises it again.
  task automatic pulseLow(input int cyc);
    @(negedge clk_sys);
    ioSupplyEnable = 1'h0;
    repeat (cyc) @(negedge clk_sys);
    ioSupplyEnable = 1'h1;
  endtask
endmodule

//--- level_sync.sv
`timescale 1ns/10ps
module level_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk_sys,
  input wire logic rstN,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } sync_t;

  sync_t s_r;
  sync_t s_nxt;

  always_comb begin
    s_nxt.stage1 = asyncIn;
    s_nxt.stage2 = s_r.stage1;
  end

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign syncOut = s_r.stage2;

endmodule

//--- persist_filter.sv
`timescale 1ns/10ps
module persist_filter #(
  parameter int unsigned CNT_W = 32
) (
  input wire logic clk_sys,
  input wire logic rstN,
  input wire logic clear,
  input wire logic sampleIn,
  input wire logic [CNT_W-1:0] limit,
  output logic filtOut
);

  // ----------------------------------------------------------------
  // The output takes a new level after it has held for limit cycles; clear forces it low at once.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic out;
  } filt_t;

  filt_t f_r;
  filt_t f_nxt;

  always_comb begin
    f_nxt = f_r;
    if (clear) begin
      f_nxt.cnt = '0;
      f_nxt.out = 1'b0;
    end else if (sampleIn == f_r.out) begin
      f_nxt.cnt = '0;
    end else if (f_r.cnt >= limit - CNT_W'(1)) begin
      f_nxt.cnt = '0;
      f_nxt.out = sampleIn;
    end else begin
      f_nxt.cnt = f_r.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      f_r <= '0;
    end else begin
      f_r <= f_nxt;
    end
  end

  assign filtOut = f_r.out;

endmodule

//--- tb_led_fault_ctrl.sv
`timescale 1ns/10ps
module tb_led_fault_ctrl;
  logic clk_sys, rst_b, regulatorOk, supplyOvComp, outputOvComp, supplyUvComp;
  logic thermalComp, adaptAtMax, boostEnable, faultPinOut, faultPinOeB;
  logic ioSupplyEnable, faultLine;
  logic supOvFlt, outOvFlt, uvFlt, thermFlt;
  logic [2:0] headroomLow, headroomMid, shortHigh, groundComp, sinkEnable;
  logic [2:0] loopInclude, openStringFault, shortedStringFault, stateCode;
  int nFail = 0;
  int numChecks = 0;
  int n;

  led_fault_ctrl #(.BACKOFF_CYC(32'h64), .OV_SLOW_CYC(32'h230), .OV_FAST_CYC(32'h32),
    .OV_REARM_CYC(32'hA0), .SUPPLY_FILT_CYC(32'h14), .UV_FILT_CYC(32'h14)) dut_u (
    .clk_sys, .rst_b, .regulatorOk, .ioSupplyEnable, .supplyOvComp, .outputOvComp,
    .supplyUvComp, .thermalComp, .adaptAtMax, .headroomLow, .headroomMid, .shortHigh,
    .groundComp, .boostEnable, .sinkEnable, .loopInclude, .faultPinOut, .faultPinOeB,
    .supplyOvervoltageFault(supOvFlt), .outputOvervoltageFault(outOvFlt),
    .supplyUndervoltageFault(uvFlt), .thermalShutdownFault(thermFlt), .openStringFault,
    .shortedStringFault, .stateCode);

  led_host_model host_u (.clk_sys, .faultPinOut, .faultPinOeB, .ioSupplyEnable,
    .faultLine);

  // --------
  // Helpers
  // --------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    numChecks++;
    if (got !== exp) begin
      nFail++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic chkR(input string what, input int lo, input int hi, input int got);
    numChecks++;
    if (got < lo || got > hi) begin
      nFail++;
      $display("CHECK FAILED %s expected %0d to %0d seen %0d", what, lo, hi, got);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clk_sys);
  endtask

  task automatic waitState(input logic [2:0] st, input int lim);
    n = 0;
    while (stateCode !== st && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
  endtask

  task automatic summarize;
    $display("Checks %0d, mismatches %0d", numChecks, nFail);
    if (nFail == 0 && numChecks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // --------
  // Scenarios
  // --------
  task automatic tPowerUp;
    cyc(4);
    chk("state", 8'h00, stateCode);
    regulatorOk = 1'h1;
    waitState(3'h1, 10);
    chk("state", 8'h01, stateCode);
    supplyOvComp = 1'h1;
    thermalComp = 1'h1;
    cyc(50);
    chk("state", 8'h01, stateCode);
    supplyOvComp = 1'h0;
    thermalComp = 1'h0;
    cyc(60);
    groundComp = 3'h4;
    host_u.setEnable(1'h1);
    waitState(3'h2, 10);
    cyc(2);
    chk("boost", 8'h01, boostEnable);
    waitState(3'h3, 1300);
    chkR("startup", 1200, 1260, n);
    cyc(2);
    chk("sinks", 8'h03, sinkEnable);
    chk("loop", 8'h03, loopInclude);
    chk("fault", 8'h01, faultLine);
    groundComp = 3'h0;
  endtask

  task automatic tClear(input int len, input logic [2:0] eOpen, input logic [2:0] eShort);
    fork
      host_u.pulseLow(len);
      begin
        cyc(len / 2);
        chk("sinks", 8'h00, sinkEnable);
        chk("fault", 8'h01, faultLine);
        chk("state", 8'h03, stateCode);
      end
    join
    cyc(10);
    chk("open", eOpen, openStringFault);
    chk("short", eShort, shortedStringFault);
    chk("fault", (eOpen | eShort) == 3'h0, faultLine);
  endtask

  task automatic tOpen;
    adaptAtMax = 1'h1;
    headroomLow = 3'h5;
    cyc(60);
    headroomLow = 3'h0;
    cyc(150);
    chk("open", 8'h00, openStringFault);
    headroomLow = 3'h5;
    cyc(200);
    chk("open", 8'h01, openStringFault);
    chk("sinks", 8'h02, sinkEnable);
    chk("loop", 8'h02, loopInclude);
    chk("state", 8'h03, stateCode);
    chk("fault", 8'h00, faultLine);
    headroomLow = 3'h0;
    adaptAtMax = 1'h0;
    cyc(10);
    tClear(1000, 3'h0, 3'h0);
    chk("sinks", 8'h03, sinkEnable);
  endtask

  task automatic tShort;
    headroomMid = 3'h1;
    shortHigh = 3'h2;
    cyc(200);
    chk("short", 8'h00, shortedStringFault);
    headroomMid = 3'h0;
    cyc(200);
    chk("short", 8'h02, shortedStringFault);
    chk("sinks", 8'h01, sinkEnable);
    chk("loop", 8'h01, loopInclude);
    chk("state", 8'h03, stateCode);
    shortHigh = 3'h0;
    cyc(10);
    tClear(100, 3'h0, 3'h2);
    tClear(1000, 3'h0, 3'h0);
  endtask

  task automatic setComp(input int sel, input logic v);
    if (sel == 0) begin
      supplyOvComp = v;
    end else begin
      supplyUvComp = v;
    end
  endtask

  task automatic tSupply(input int sel);
    setComp(sel, 1'h1);
    cyc(10);
    setComp(sel, 1'h0);
    cyc(40);
    chk("state", 8'h03, stateCode);
    setComp(sel, 1'h1);
    waitState(3'h4, 100);
    chkR("filter", 20, 30, n);
    chk("flag", 8'h01, sel == 0 ? supOvFlt : uvFlt);
    setComp(sel, 1'h0);
    cyc(2);
    chk("boost", 8'h00, boostEnable);
    chk("sinks", 8'h00, sinkEnable);
    chk("fault", 8'h00, faultLine);
    cyc(80);
    chk("state", 8'h04, stateCode);
    chk("flag", 8'h00, sel == 0 ? supOvFlt : uvFlt);
    waitState(3'h3, 60);
    chkR("backoff", 12, 25, n);
    cyc(2);
    chk("fault", 8'h01, faultLine);
    chk("sinks", 8'h03, sinkEnable);
  endtask

  task automatic tThermal;
    thermalComp = 1'h1;
    waitState(3'h4, 6);
    chk("state", 8'h04, stateCode);
    chk("therm", 8'h01, thermFlt);
    cyc(200);
    chk("state", 8'h04, stateCode);
    thermalComp = 1'h0;
    waitState(3'h3, 120);
    chk("state", 8'h03, stateCode);
    chk("therm", 8'h00, thermFlt);
  endtask

  task automatic ovRun(input int lo, input int hi);
    outputOvComp = 1'h1;
    waitState(3'h4, 700);
    chkR("ov filter", lo, hi, n);
    chk("ov flag", 8'h01, outOvFlt);
    outputOvComp = 1'h0;
    waitState(3'h3, 150);
    chk("state", 8'h03, stateCode);
    chk("ov flag", 8'h00, outOvFlt);
  endtask

  task automatic tStandby;
    host_u.setEnable(1'h0);
    waitState(3'h1, 3000);
    chkR("standby", 2495, 2515, n);
    chk("boost", 8'h00, boostEnable);
    host_u.setEnable(1'h1);
    waitState(3'h2, 10);
    waitState(3'h3, 1300);
    chk("state", 8'h03, stateCode);
  endtask

  // --------
  // Run
  // --------
  initial begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end

  initial begin
    cyc(40000);
    nFail++;
    summarize();
  end

  initial begin
    {rst_b, regulatorOk, supplyOvComp, outputOvComp, supplyUvComp} = 5'h00;
    {thermalComp, adaptAtMax} = 2'h0;
    {headroomLow, headroomMid, shortHigh, groundComp} = 12'h000;
    cyc(5);
    rst_b = 1'h1;
    tPowerUp();
    tOpen();
    tShort();
    tSupply(0);
    tSupply(1);
    tThermal();
    ovRun(555, 570);
    ovRun(45, 60);
    cyc(200);
    ovRun(555, 570);
    tStandby();
    summarize();
  end
endmodule
